// file: core/bridge_pkg.sv
// constants for the instrument bus pass-through bridge
package bridge_pkg;
	localparam logic [4:0] default_forward_primary = 5'h11; // primary 17
	localparam logic [2:0] default_select_code = 3'h7;
	localparam logic [4:0] graphics_target = 5'h1F; // 31
	localparam logic [12:0] x_max = 13'h1501; // 5377
	localparam logic [12:0] y_max = 13'h0FFF; // 4095
	localparam logic [12:0] cell_w = 13'h0040; // 64
	localparam logic [12:0] cell_h = 13'h0080; // 128
	localparam logic [12:0] glyph_w = 13'h0030; // 48
	localparam logic [12:0] glyph_h = 13'h0040; // 64
	localparam logic [7:0] etx_char = 8'h03;
	localparam logic [7:0] ch_comma = 8'h2C;
	localparam logic [7:0] ch_minus = 8'h2D;
	localparam logic [7:0] ch_semi = 8'h3B;
	localparam logic [7:0] ch_space = 8'h20;
	localparam logic [7:0] ch_lf = 8'h0A;
	localparam logic [7:0] ch_zero = 8'h30;
	localparam logic [7:0] ch_nine = 8'h39;
	// secondary bus control command kinds
	localparam logic [1:0] sec_cmd_none = 2'h0;
	localparam logic [1:0] sec_cmd_local = 2'h1;
	localparam logic [1:0] sec_cmd_remote = 2'h2;
endpackage : bridge_pkg

// file: core/graphics_engine.sv
// user-display graphics instruction interpreter
`timescale 1ns/1ps
module graphics_engine (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// instruction byte stream
	input wire logic in_valid,
	input wire logic [7:0] in_data,
	// vector output
	output logic vec_valid,
	output logic vec_visible,
	output logic [12:0] vec_x0,
	output logic [12:0] vec_y0,
	output logic [12:0] vec_x1,
	output logic [12:0] vec_y1,
	// character output
	output logic char_valid,
	output logic [7:0] char_code,
	output logic [12:0] char_x,
	output logic [12:0] char_y,
	// screen clear
	output logic clear_screen,
	// pen state
	output logic pen_down,
	output logic relative_mode
);
	typedef enum logic [3:0] {
		g_cmd1 = 4'b0001,
		g_cmd2 = 4'b0010,
		g_args = 4'b0100,
		g_label = 4'b1000
	} gstate_t;
	gstate_t state;
	logic [7:0] first;
	logic [13:0] num;
	logic neg;
	logic have_digit;
	logic have_x;
	logic [13:0] px;
	logic [12:0] cur_x;
	logic [12:0] cur_y;
	logic [12:0] lab_x;
	logic is_digit;
	logic [13:0] signed_num;
	logic [13:0] tx;
	logic [13:0] ty;
	logic [12:0] nx;
	logic [12:0] ny;
	logic [7:0] up;

	assign up = (in_data >= 8'h61 && in_data <= 8'h7A) ? (in_data - 8'h20) : in_data;
	assign is_digit = in_data >= bridge_pkg::ch_zero && in_data <= bridge_pkg::ch_nine;
	assign signed_num = neg ? (14'h0000 - num) : num;

	// target coordinates, clamped into the plotting space
	always_comb begin
		tx = relative_mode ? (px + {1'b0, cur_x}) : px;
		ty = relative_mode ? (signed_num + {1'b0, cur_y}) : signed_num;
		if (tx[13])
			nx = 13'h0000;
		else if (tx[12:0] > bridge_pkg::x_max)
			nx = bridge_pkg::x_max;
		else
			nx = tx[12:0];
		if (ty[13])
			ny = 13'h0000;
		else if (ty[12:0] > bridge_pkg::y_max)
			ny = bridge_pkg::y_max;
		else
			ny = ty[12:0];
	end

	// instruction parser
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= g_cmd1;
			first <= 8'h00;
			num <= 14'h0000;
			neg <= 1'b0;
			have_digit <= 1'b0;
			have_x <= 1'b0;
			px <= 14'h0000;
			cur_x <= 13'h0000;
			cur_y <= 13'h0000;
			lab_x <= 13'h0000;
			pen_down <= 1'b0;
			relative_mode <= 1'b0;
			vec_valid <= 1'b0;
			vec_visible <= 1'b0;
			vec_x0 <= 13'h0000;
			vec_y0 <= 13'h0000;
			vec_x1 <= 13'h0000;
			vec_y1 <= 13'h0000;
			char_valid <= 1'b0;
			char_code <= 8'h00;
			char_x <= 13'h0000;
			char_y <= 13'h0000;
			clear_screen <= 1'b0;
		end else begin
			vec_valid <= 1'b0;
			char_valid <= 1'b0;
			clear_screen <= 1'b0;
			if (in_valid) begin
				case (state)
					g_cmd1: begin
						if (up >= 8'h41 && up <= 8'h5A) begin
							first <= up;
							state <= g_cmd2;
						end
					end
					g_cmd2: begin
						state <= g_cmd1;
						num <= 14'h0000;
						neg <= 1'b0;
						have_digit <= 1'b0;
						have_x <= 1'b0;
						if (first == 8'h50 && up == 8'h41) begin
							relative_mode <= 1'b0;
							state <= g_args;
						end else if (first == 8'h50 && up == 8'h52) begin
							relative_mode <= 1'b1;
							state <= g_args;
						end else if (first == 8'h50 && up == 8'h55) begin
							pen_down <= 1'b0;
						end else if (first == 8'h50 && up == 8'h44) begin
							pen_down <= 1'b1;
						end else if (first == 8'h44 && up == 8'h46) begin
							pen_down <= 1'b0;
							relative_mode <= 1'b0;
						end else if (first == 8'h43 && up == 8'h53) begin
							clear_screen <= 1'b1;
						end else if (first == 8'h50 && up == 8'h47) begin
							clear_screen <= 1'b1;
						end else if (first == 8'h4C && up == 8'h42) begin
							lab_x <= cur_x;
							state <= g_label;
						end
					end
					g_args: begin
						if (is_digit) begin
							num <= 14'((num << 3) + (num << 1) + {6'h00, in_data - bridge_pkg::ch_zero});
							have_digit <= 1'b1;
						end else if (in_data == bridge_pkg::ch_minus) begin
							neg <= 1'b1;
						end else if (have_digit) begin
							num <= 14'h0000;
							neg <= 1'b0;
							have_digit <= 1'b0;
							if (!have_x) begin
								px <= signed_num;
								have_x <= 1'b1;
							end else begin
								// each x,y pair moves the pen in turn
								have_x <= 1'b0;
								vec_valid <= 1'b1;
								vec_visible <= pen_down;
								vec_x0 <= cur_x;
								vec_y0 <= cur_y;
								vec_x1 <= nx;
								vec_y1 <= ny;
								cur_x <= nx;
								cur_y <= ny;
							end
							if (in_data == bridge_pkg::ch_semi || up >= 8'h41 && up <= 8'h5A) begin
								state <= g_cmd1;
								if (up >= 8'h41 && up <= 8'h5A) begin
									first <= up;
									state <= g_cmd2;
								end
							end
						end else if (up >= 8'h41 && up <= 8'h5A) begin
							first <= up;
							state <= g_cmd2;
						end else if (in_data == bridge_pkg::ch_semi) begin
							state <= g_cmd1;
						end
					end
					g_label: begin
						if (in_data == bridge_pkg::etx_char) begin
							state <= g_cmd1;
						end else begin
							// one 64x128 cell per character
							char_valid <= 1'b1;
							char_code <= in_data;
							char_x <= cur_x;
							char_y <= cur_y;
							if (in_data == ch_lf_const()) begin
								cur_x <= lab_x;
								cur_y <= (cur_y >= bridge_pkg::cell_h) ? 13'(cur_y - bridge_pkg::cell_h) : 13'h0000;
							end else if (cur_x <= 13'(bridge_pkg::x_max - bridge_pkg::cell_w)) begin
								cur_x <= 13'(cur_x + bridge_pkg::cell_w);
							end
						end
					end
					default: state <= g_cmd1;
				endcase
			end
		end
	end

	function automatic logic [7:0] ch_lf_const();
		ch_lf_const = bridge_pkg::ch_lf;
	endfunction : ch_lf_const
endmodule : graphics_engine

// file: core/instrument_bus_pass_through.sv
// pass-through bridge between host bus and secondary bus
`timescale 1ns/1ps
module instrument_bus_pass_through (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// host bus addressing events (from host bus interface)
	input wire logic host_listen_own,
	input wire logic host_listen_forward,
	input wire logic host_talk_forward,
	input wire logic host_unaddress,
	// host data bytes to the bridge
	input wire logic host_in_valid,
	input wire logic [7:0] host_in_data,
	output logic host_in_ready,
	// host data bytes from the bridge
	output logic host_out_valid,
	output logic [7:0] host_out_data,
	output logic host_out_eoi,
	input wire logic host_out_ready,
	// local command decoder results
	input wire logic select_target_valid,
	input wire logic [4:0] select_forward_target,
	input wire logic set_forward_primary_valid,
	input wire logic [4:0] set_forward_primary,
	// own-address bytes to the local command processor
	output logic own_cmd_valid,
	output logic [7:0] own_cmd_data,
	// forwarding address currently in use
	output logic [2:0] forward_select_code,
	output logic [4:0] forward_primary,
	// secondary bus byte output
	output logic sec_tx_valid,
	output logic [7:0] sec_tx_data,
	output logic [4:0] sec_tx_listener,
	input wire logic sec_tx_ready,
	// secondary bus byte input from talker
	input wire logic sec_rx_valid,
	input wire logic [7:0] sec_rx_data,
	input wire logic sec_rx_eoi,
	output logic sec_rx_ready,
	// secondary bus control commands
	output logic [1:0] sec_cmd,
	input wire logic sec_cmd_done,
	output logic sec_own_control,
	// measurement hold request
	output logic meas_hold,
	// graphics memory writes
	output logic vec_valid,
	output logic vec_visible,
	output logic [12:0] vec_x0,
	output logic [12:0] vec_y0,
	output logic [12:0] vec_x1,
	output logic [12:0] vec_y1,
	output logic char_valid,
	output logic [7:0] char_code,
	output logic [12:0] char_x,
	output logic [12:0] char_y,
	output logic clear_screen,
	// graphics memory housekeeping
	input wire logic plot_whole_screen,
	input wire logic store_user_display,
	input wire logic load_user_display,
	output logic user_plot_include,
	output logic user_store_req,
	output logic user_load_req
);
	typedef enum logic [3:0] {
		st_own = 4'b0001,
		st_go_local = 4'b0010,
		st_forward = 4'b0100,
		st_go_remote = 4'b1000
	} mode_t;
	mode_t mode;
	logic [4:0] target;
	logic lis_own_s1, lis_own_s2, lis_fwd_s1, lis_fwd_s2, tlk_fwd_s1, tlk_fwd_s2, unadr_s1, unadr_s2;
	logic talking;
	logic to_graphics;
	logic gfx_valid;

	// addressing strobes arrive from the host bus domain
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			lis_own_s1 <= 1'b0;
			lis_own_s2 <= 1'b0;
			lis_fwd_s1 <= 1'b0;
			lis_fwd_s2 <= 1'b0;
			tlk_fwd_s1 <= 1'b0;
			tlk_fwd_s2 <= 1'b0;
			unadr_s1 <= 1'b0;
			unadr_s2 <= 1'b0;
		end else begin
			lis_own_s1 <= host_listen_own;
			lis_own_s2 <= lis_own_s1;
			lis_fwd_s1 <= host_listen_forward;
			lis_fwd_s2 <= lis_fwd_s1;
			tlk_fwd_s1 <= host_talk_forward;
			tlk_fwd_s2 <= tlk_fwd_s1;
			unadr_s1 <= host_unaddress;
			unadr_s2 <= unadr_s1;
		end
	end

	// forwarding address and target selection
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			target <= bridge_pkg::default_forward_primary;
			forward_primary <= bridge_pkg::default_forward_primary;
		end else begin
			if (select_target_valid)
				target <= select_forward_target;
			if (set_forward_primary_valid)
				forward_primary <= set_forward_primary;
		end
	end
	assign forward_select_code = bridge_pkg::default_select_code;
	assign to_graphics = target == bridge_pkg::graphics_target;

	// ownership of the secondary bus
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mode <= st_own;
			talking <= 1'b0;
		end else begin
			if (unadr_s2)
				talking <= 1'b0;
			else if (tlk_fwd_s2)
				talking <= 1'b1;
			else if (lis_own_s2 || lis_fwd_s2)
				talking <= 1'b0;
			case (mode)
				st_own: begin
					if (lis_fwd_s2 || tlk_fwd_s2)
						mode <= st_go_local;
				end
				st_go_local: begin
					if (sec_cmd_done)
						mode <= st_forward;
				end
				st_forward: begin
					if (lis_own_s2)
						mode <= st_go_remote;
				end
				st_go_remote: begin
					if (sec_cmd_done)
						mode <= st_own;
				end
				default: mode <= st_own;
			endcase
		end
	end

	assign sec_cmd = (mode == st_go_local) ? bridge_pkg::sec_cmd_local :
		(mode == st_go_remote) ? bridge_pkg::sec_cmd_remote : bridge_pkg::sec_cmd_none;
	assign sec_own_control = mode == st_own;
	assign meas_hold = mode != st_own;

	// which path accepts host bytes; the mode admits own traffic or forward traffic, never both at once
	always_comb begin
		if (mode == st_own)
			host_in_ready = 1'b1;
		else if (mode == st_forward)
			host_in_ready = to_graphics ? 1'b1 : (!talking && sec_tx_ready);
		else
			host_in_ready = 1'b0;
	end

	// own-address bytes pass to the local command processor
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			own_cmd_valid <= 1'b0;
			own_cmd_data <= 8'h00;
		end else begin
			own_cmd_valid <= host_in_valid && mode == st_own;
			if (host_in_valid && mode == st_own)
				own_cmd_data <= host_in_data;
		end
	end

	// forwarded bytes relayed to the target, unchanged and in order
	assign sec_tx_valid = host_in_valid && mode == st_forward && !to_graphics && !talking;
	assign sec_tx_data = host_in_data;
	assign sec_tx_listener = target;
	// only data bytes pass; host bus commands and handshakes never cross
	assign gfx_valid = host_in_valid && mode == st_forward && to_graphics;

	// read-back path from the talking target
	assign sec_rx_ready = mode == st_forward && talking && !to_graphics && host_out_ready;
	assign host_out_valid = sec_rx_valid && sec_rx_ready;
	assign host_out_data = sec_rx_data;
	assign host_out_eoi = sec_rx_eoi;

	graphics_engine u_graphics (
		.clk(clk),
		.nrst(nrst),
		.in_valid(gfx_valid),
		.in_data(host_in_data),
		.vec_valid(vec_valid),
		.vec_visible(vec_visible),
		.vec_x0(vec_x0),
		.vec_y0(vec_y0),
		.vec_x1(vec_x1),
		.vec_y1(vec_y1),
		.char_valid(char_valid),
		.char_code(char_code),
		.char_x(char_x),
		.char_y(char_y),
		.clear_screen(clear_screen),
		.pen_down(),
		.relative_mode()
	);

	// graphics memory joins plots, disc store and reload
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			user_plot_include <= 1'b0;
			user_store_req <= 1'b0;
			user_load_req <= 1'b0;
		end else begin
			user_plot_include <= plot_whole_screen;
			user_store_req <= store_user_display;
			user_load_req <= load_user_display;
		end
	end
endmodule : instrument_bus_pass_through

// file: verif/bridge_chk.sv
// port assertions for the pass-through bridge
`timescale 1ns/1ps
module bridge_chk (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// host side
	input wire logic host_in_valid,
	input wire logic [7:0] host_in_data,
	input wire logic host_in_ready,
	input wire logic host_out_valid,
	input wire logic [7:0] host_out_data,
	input wire logic [7:0] sec_rx_data,
	input wire logic set_forward_primary_valid,
	input wire logic [4:0] set_forward_primary,
	input wire logic [4:0] forward_primary,
	input wire logic [2:0] forward_select_code,
	input wire logic own_cmd_valid,
	input wire logic [7:0] own_cmd_data,
	// secondary side and modes
	input wire logic sec_tx_valid,
	input wire logic [7:0] sec_tx_data,
	input wire logic [4:0] sec_tx_listener,
	input wire logic [1:0] sec_cmd,
	input wire logic sec_cmd_done,
	input wire logic sec_own_control,
	input wire logic meas_hold,
	// graphics and housekeeping
	input wire logic vec_valid,
	input wire logic [12:0] vec_x1,
	input wire logic [12:0] vec_y1,
	input wire logic plot_whole_screen,
	input wire logic user_plot_include
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// steps of the mode hand-over and of an own byte
	sequence s_cmd_wait;
		sec_cmd != bridge_pkg::sec_cmd_none && !sec_cmd_done;
	endsequence
	sequence s_own_take;
		host_in_valid && host_in_ready && sec_own_control && !meas_hold;
	endsequence
	sequence s_remote_done;
		sec_cmd == bridge_pkg::sec_cmd_remote && sec_cmd_done;
	endsequence
	a_own_byte_next: assert property (s_own_take |=> own_cmd_valid && own_cmd_data == $past(host_in_data))
		else $error("own byte not passed on");
	a_relay_plain: assert property (sec_tx_valid |-> host_in_valid && sec_tx_data == host_in_data
		&& sec_tx_listener != bridge_pkg::graphics_target)
		else $error("relayed byte differs");
	a_local_hold: assert property (sec_cmd == bridge_pkg::sec_cmd_local |-> meas_hold && !host_in_ready)
		else $error("no hold during local");
	a_cmd_stands: assert property (s_cmd_wait |=> sec_cmd == $past(sec_cmd))
		else $error("command dropped early");
	a_remote_back: assert property (s_remote_done |-> ##[1:3] sec_own_control)
		else $error("control not taken back");
	a_read_pass: assert property (host_out_valid |-> host_out_data == sec_rx_data)
		else $error("read byte differs");
	a_primary_set: assert property (set_forward_primary_valid |=> forward_primary == $past(set_forward_primary))
		else $error("primary not updated");
	a_select_code: assert property (forward_select_code == bridge_pkg::default_select_code)
		else $error("select code wrong");
	a_vec_bounds: assert property (vec_valid |-> vec_x1 <= bridge_pkg::x_max && vec_y1 <= bridge_pkg::y_max)
		else $error("vector off plot space");
	a_plot_include: assert property (plot_whole_screen |=> user_plot_include)
		else $error("plot include missing");
endmodule : bridge_chk

bind instrument_bus_pass_through bridge_chk u_bridge_chk (.clk, .nrst, .host_in_valid, .host_in_data,
	.host_in_ready, .host_out_valid, .host_out_data, .sec_rx_data, .set_forward_primary_valid,
	.set_forward_primary, .forward_primary, .forward_select_code, .own_cmd_valid, .own_cmd_data,
	.sec_tx_valid, .sec_tx_data, .sec_tx_listener, .sec_cmd, .sec_cmd_done, .sec_own_control,
	.meas_hold, .vec_valid, .vec_x1, .vec_y1, .plot_whole_screen, .user_plot_include);

// file: verif/host_model.sv
// host computer model: byte writer and reader
`timescale 1ns/1ps
module host_model (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// bytes to the bridge
	output logic in_valid,
	output logic [7:0] in_data,
	input wire logic in_ready,
	// bytes from the bridge
	input wire logic out_valid,
	input wire logic [7:0] out_data,
	input wire logic out_eoi,
	output logic out_ready
);
	logic [7:0] tx_q[$];
	logic [7:0] rx_q[$];
	logic took;
	logic reading;
	initial begin
		took = 0;
		reading = 0;
	end
	// handshakes sampled on the rising edge
	always @(posedge clk) begin
		took = in_valid && in_ready && nrst;
		if (out_valid && out_ready) begin
			rx_q.push_back(out_data);
			if (out_eoi)
				reading = 0;
		end
	end
	// next byte only after the last was taken; released data flips
	always @(negedge clk) begin
		if (!nrst) begin
			in_valid <= 1'b0;
			in_data <= 8'h00;
			out_ready <= 1'b0;
		end else begin
			if (took || !in_valid) begin
				in_valid <= (tx_q.size() != 0);
				in_data <= (tx_q.size() != 0) ? tx_q.pop_front() : ~in_data;
			end
			out_ready <= reading;
		end
	end
	// queue a byte, open or end a read
	task put(input logic [7:0] b);
		tx_q.push_back(b);
	endtask : put
	task start_read();
		reading = 1;
	endtask : start_read
	task end_read();
		reading = 0;
	endtask : end_read
endmodule : host_model

// file: verif/instrument_bus_pass_through_tb.sv
// self-checking bench for the pass-through bridge
`timescale 1ns/1ps
module instrument_bus_pass_through_tb;
	logic clk = 1'b0;
	logic nrst, host_listen_own, host_listen_forward, host_talk_forward, host_unaddress;
	logic host_in_valid, host_in_ready, host_out_valid, host_out_eoi, host_out_ready;
	logic [7:0] host_in_data, host_out_data, own_cmd_data, sec_tx_data, sec_rx_data, char_code;
	logic select_target_valid, set_forward_primary_valid, own_cmd_valid;
	logic [4:0] select_forward_target, set_forward_primary, forward_primary, sec_tx_listener;
	logic [2:0] forward_select_code;
	logic sec_tx_valid, sec_tx_ready, sec_rx_valid, sec_rx_eoi, sec_rx_ready, sec_cmd_done, cmd_wait;
	logic [1:0] sec_cmd;
	logic sec_own_control, meas_hold, vec_valid, vec_visible, char_valid, clear_screen;
	logic [12:0] vec_x0, vec_y0, vec_x1, vec_y1, char_x, char_y;
	logic plot_whole_screen, store_user_display, load_user_display;
	logic user_plot_include, user_store_req, user_load_req;
	int n_fail, n_checks, n_clear;
	logic [12:0] tx_seen[$];
	logic [7:0] own_seen[$];
	logic [1:0] cmd_seen[$];
	logic [52:0] vec_seen[$];
	logic [33:0] chr_seen[$];
	instrument_bus_pass_through u_instrument_bus_pass_through (.clk, .nrst, .host_listen_own,
		.host_listen_forward, .host_talk_forward, .host_unaddress, .host_in_valid, .host_in_data,
		.host_in_ready, .host_out_valid, .host_out_data, .host_out_eoi, .host_out_ready,
		.select_target_valid, .select_forward_target, .set_forward_primary_valid, .set_forward_primary,
		.own_cmd_valid, .own_cmd_data, .forward_select_code, .forward_primary, .sec_tx_valid,
		.sec_tx_data, .sec_tx_listener, .sec_tx_ready, .sec_rx_valid, .sec_rx_data, .sec_rx_eoi,
		.sec_rx_ready, .sec_cmd, .sec_cmd_done, .sec_own_control, .meas_hold, .vec_valid, .vec_visible,
		.vec_x0, .vec_y0, .vec_x1, .vec_y1, .char_valid, .char_code, .char_x, .char_y, .clear_screen,
		.plot_whole_screen, .store_user_display, .load_user_display, .user_plot_include,
		.user_store_req, .user_load_req);
	host_model u_host_model (.clk, .nrst, .in_valid(host_in_valid), .in_data(host_in_data),
		.in_ready(host_in_ready), .out_valid(host_out_valid), .out_data(host_out_data),
		.out_eoi(host_out_eoi), .out_ready(host_out_ready));
	// clock
	initial begin
		forever #5 clk = ~clk;
	end
	// secondary bus answers each control command with one done pulse, a cycle late
	always @(negedge clk) begin
		cmd_wait <= (sec_cmd !== 2'h0) && !sec_cmd_done;
		sec_cmd_done <= cmd_wait && (sec_cmd !== 2'h0) && !sec_cmd_done;
	end
	// record what leaves the bridge
	always @(posedge clk) begin
		if (sec_tx_valid && sec_tx_ready)
			tx_seen.push_back({sec_tx_listener, sec_tx_data});
		if (own_cmd_valid === 1'b1)
			own_seen.push_back(own_cmd_data);
		if (sec_cmd_done)
			cmd_seen.push_back(sec_cmd);
		if (vec_valid === 1'b1)
			vec_seen.push_back({vec_visible, vec_x0, vec_y0, vec_x1, vec_y1});
		if (char_valid === 1'b1)
			chr_seen.push_back({char_code, char_x, char_y});
		if (clear_screen === 1'b1)
			n_clear++;
	end
	task check(input string what, input logic [63:0] exp, input logic [63:0] got);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, got);
		end
	endtask : check
	function automatic logic [52:0] v(input logic p, input logic [12:0] a, b, c, d);
		return {p, a, b, c, d};
	endfunction : v
	task send(input string s);
		foreach (s[i]) u_host_model.put(s[i]);
		for (int i = 0; i < 400 && (u_host_model.tx_q.size() != 0 || host_in_valid); i++) @(negedge clk);
		repeat (3) @(negedge clk);
	endtask : send
	task pick(input logic [4:0] t);
		select_forward_target = t;
		select_target_valid = 1;
		@(negedge clk);
		select_target_valid = 0;
	endtask : pick
	task sec_give(input logic [7:0] b, input logic e);
		sec_rx_valid = 1;
		sec_rx_data = b;
		sec_rx_eoi = e;
		@(posedge clk);
		for (int i = 0; i < 50 && sec_rx_ready !== 1'b1; i++) @(posedge clk);
		@(negedge clk);
	endtask : sec_give
	task t_reset_primary();
		check("primary", 5'h11, forward_primary);
		check("select code", 3'h7, forward_select_code);
		check("own control", 1'b1, sec_own_control);
		set_forward_primary = 5'h15;
		set_forward_primary_valid = 1;
		@(negedge clk);
		set_forward_primary_valid = 0;
		@(negedge clk);
		check("primary set", 5'h15, forward_primary);
	endtask : t_reset_primary
	task t_forward();
		pick(5'h01);
		host_listen_forward = 1;
		sec_tx_ready = 0;
		repeat (8) @(negedge clk);
		check("hold", 1'b1, meas_hold);
		check("local cmd", 2'h1, cmd_seen[$]);
		fork
			begin
				repeat (6) @(negedge clk);
				sec_tx_ready = 1;
			end
		join_none
		send("AB\014");
		check("tx count", 3, tx_seen.size());
		check("tx 0", {5'h01, 8'h41}, tx_seen[0]);
		check("tx 1", {5'h01, 8'h42}, tx_seen[1]);
		check("tx 2", {5'h01, 8'h0C}, tx_seen[2]);
	endtask : t_forward
	task t_read_own();
		host_listen_forward = 0;
		host_talk_forward = 1;
		u_host_model.start_read();
		repeat (4) @(negedge clk);
		sec_give(8'h4F, 0);
		sec_give(8'h4B, 1);
		sec_rx_valid = 0;
		sec_rx_data = ~sec_rx_data;
		repeat (3) @(negedge clk);
		u_host_model.end_read();
		check("rx count", 2, u_host_model.rx_q.size());
		check("rx 0", 8'h4F, u_host_model.rx_q[0]);
		check("rx 1", 8'h4B, u_host_model.rx_q[1]);
		host_talk_forward = 0;
		host_unaddress = 1;
		@(negedge clk);
		host_unaddress = 0;
		host_listen_own = 1;
		repeat (8) @(negedge clk);
		check("remote cmd", 2'h2, cmd_seen[$]);
		check("control back", 1'b1, sec_own_control);
		send("X");
		check("own byte", 8'h58, own_seen[$]);
		host_listen_own = 0;
		host_listen_forward = 1;
		repeat (8) @(negedge clk);
		send("Q");
		check("kept target", {5'h01, 8'h51}, tx_seen[$]);
	endtask : t_read_own
	task t_graphics();
		int n0;
		n0 = tx_seen.size();
		pick(bridge_pkg::graphics_target);
		send("DF;PA 10,20;PD;PR 5,-3;PA 6000,5000;PR -5377,-4095;LBAB\003CS;");
		check("no relay", n0, tx_seen.size());
		check("vec count", 4, vec_seen.size());
		check("vec blank", v(0, 13'h0, 13'h0, 13'h000A, 13'h0014), vec_seen[0]);
		check("vec rel", v(1, 13'h000A, 13'h0014, 13'h000F, 13'h0011), vec_seen[1]);
		check("vec clamp", v(1, 13'h000F, 13'h0011, bridge_pkg::x_max, bridge_pkg::y_max), vec_seen[2]);
		check("vec neg", v(1, bridge_pkg::x_max, bridge_pkg::y_max, 13'h0, 13'h0), vec_seen[3]);
		check("chr count", 2, chr_seen.size());
		check("chr 0", {8'h41, 13'h0, 13'h0}, chr_seen[0]);
		check("chr 1", {8'h42, bridge_pkg::cell_w, 13'h0}, chr_seen[1]);
		check("clear", 1, n_clear);
	endtask : t_graphics
	task t_house();
		plot_whole_screen = 1;
		store_user_display = 1;
		load_user_display = 1;
		@(negedge clk);
		plot_whole_screen = 0;
		store_user_display = 0;
		load_user_display = 0;
		check("plot", 1'b1, user_plot_include);
		check("store", 1'b1, user_store_req);
		check("load", 1'b1, user_load_req);
	endtask : t_house
	task final_report();
		$display("checks %0d failures %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : final_report
	// watchdog against a hang
	initial begin
		#100000;
		n_fail++;
		final_report();
	end
	// main sequence
	initial begin
		{nrst, host_listen_own, host_listen_forward, host_talk_forward, host_unaddress} = 5'h00;
		{select_target_valid, set_forward_primary_valid, sec_tx_ready, sec_rx_valid, sec_rx_eoi} = 5'h00;
		{plot_whole_screen, store_user_display, load_user_display} = 3'h0;
		{select_forward_target, set_forward_primary, sec_rx_data} = 18'h0;
		n_fail = 0;
		n_checks = 0;
		n_clear = 0;
		repeat (5) @(negedge clk);
		nrst = 1;
		@(negedge clk);
		t_reset_primary();
		t_forward();
		t_read_own();
		t_graphics();
		t_house();
		final_report();
	end
endmodule : instrument_bus_pass_through_tb
